// File: owc_pkg.sv
// Package for the oscillator warm-up counter: register map, field positions, resets.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package owc_pkg;
   localparam logic [7:0] ADR_SYS_CTRL2 = 8'h00;
   localparam logic [7:0] ADR_LOWER_CTRL = 8'h04;
   localparam logic [7:0] ADR_UPPER_CTRL = 8'h08;
   localparam logic [7:0] ADR_PERIOD = 8'h0C;
   localparam logic [7:0] ADR_COUNT = 8'h10;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADR_IRQ_MASK = 8'h18;
   localparam int SYS_SLOW_SEL_BIT = 5;
   localparam int SYS_SLOW_EN_BIT = 6;
   localparam int SYS_FAST_EN_BIT = 7;
   localparam int UPPER_RUN_BIT = 3;
   localparam int OUT_FF_BIT = 7;
   localparam int CLK_SEL_LSB = 4;
   localparam logic [2:0] UPPER_MODE_WARMUP = 3'h5;
   localparam logic [2:0] LOWER_MODE_CASCADE = 3'h3;
   localparam logic [2:0] SRC_SLOW = 3'h4;
   localparam logic [2:0] SRC_FAST = 3'h6;
   localparam logic [7:0] SYS_CTRL2_RST = 8'h80;
   localparam logic [7:0] STAGE_CTRL_RST = 8'h00;
   localparam logic [15:0] PERIOD_RST = 16'hFFFF;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   typedef struct packed {
      logic fast_en;
      logic slow_en;
      logic slow_sel;
   } owc_osc_s;

   typedef struct packed {
      logic [7:0] adr;
      logic we;
      logic [31:0] dat;
      logic [3:0] sel;
   } owc_req_s;
endpackage : owc_pkg

// File: owc_edge.sv
// Rising-edge detector for the tick of the oscillator being warmed up.
// Assumes the tick input is already synchronous to clk_i.
`timescale 1ns/10ps
module owc_edge
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic lvl_i,
   output logic rise_o
);
   logic prev_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         prev_r <= 1'b0;
      else if (ce_i)
         prev_r <= lvl_i;
   end

   assign rise_o = ce_i & lvl_i & ~prev_r;
endmodule : owc_edge

// File: owc_counter.sv
// Cascaded 16-bit up-counter: warm-up match on upper byte only.
// Assumes cnt_en_i is a one-cycle tick of the selected oscillator.
`timescale 1ns/10ps
module owc_counter
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic run_i,
   input wire logic cnt_en_i,
   input wire logic [7:0] cmp_upper_i,
   output logic [15:0] count_o,
   output logic match_o
);
   logic [15:0] count_r;
   logic hit;

   // Lower byte of the compare value plays no part in warm-up matching
   assign hit = (count_r[15:8] == cmp_upper_i) && (cmp_upper_i != 8'h00);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count_r <= 16'h0000;
         match_o <= 1'b0;
      end
      else if (ce_i)
      begin
         match_o <= 1'b0;
         if (!run_i)
            count_r <= 16'h0000;
         else if (cnt_en_i)
         begin
            if (hit)
            begin
               count_r <= 16'h0000;
               match_o <= 1'b1;
            end
            else
               count_r <= count_r + 16'h0001;
         end
      end
   end

   assign count_o = count_r;
endmodule : owc_counter

// File: owc_top.sv
// Oscillator warm-up counter with Wishbone register access and one interrupt.
// Assumes slow_tick_i and fast_tick_i are oscillator levels synchronous to clk_i.
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
module owc_top
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic slow_tick_i,
   input wire logic fast_tick_i,
   output owc_pkg::owc_osc_s osc_o,
   output logic lower_output_flipflop_o,
   output logic upper_output_flipflop_o,
   output logic irq_o
);
   import owc_pkg::*;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_DONE = 3'b100
   } owc_state_e;

   owc_state_e state_r;
   owc_state_e state_nxt;
   owc_req_s req;
   logic [7:0] system_control_two_r;
   logic [7:0] lower_stage_control_r;
   logic [7:0] upper_stage_control_r;
   logic [7:0] period_compare_lower_r;
   logic [7:0] period_compare_upper_r;
   logic irq_stat_r;
   logic irq_mask_r;
   logic [15:0] count;
   logic match;
   logic slow_rise;
   logic fast_rise;
   logic tick;
   logic warmup_mode;
   logic upper_stage_run;
   logic wr_stb;
   logic [31:0] rd_data;

   // Byte-lane write helper for the low byte of a register
   function automatic logic [7:0] wr_byte(input logic [7:0] old, input owc_req_s r);
      wr_byte = r.sel[0] ? r.dat[7:0] : old;
   endfunction : wr_byte

   function automatic logic hit_adr(input owc_req_s r, input logic [7:0] a);
      hit_adr = (r.adr == a);
   endfunction : hit_adr

   assign req = '{adr: adr_i, we: we_i, dat: dat_i, sel: sel_i};
   assign wr_stb = cyc_i & stb_i & we_i & ~ack_o;

   assign warmup_mode = (upper_stage_control_r[2:0] == UPPER_MODE_WARMUP)
                        && (lower_stage_control_r[2:0] == LOWER_MODE_CASCADE);
   assign upper_stage_run = upper_stage_control_r[UPPER_RUN_BIT];

   owc_edge u_slow_edge
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .lvl_i(slow_tick_i),
      .rise_o(slow_rise)
   );

   owc_edge u_fast_edge
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .lvl_i(fast_tick_i),
      .rise_o(fast_rise)
   );

   // Counting source follows the lower-stage clock select; a stopped oscillator gives no ticks
   always_comb
   begin
      case (lower_stage_control_r[CLK_SEL_LSB +: 3])
         SRC_SLOW: tick = slow_rise & system_control_two_r[SYS_SLOW_EN_BIT];
         SRC_FAST: tick = fast_rise & system_control_two_r[SYS_FAST_EN_BIT];
         default: tick = 1'b0;
      endcase
   end

   owc_counter u_counter
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .run_i(state_r == ST_RUN),
      .cnt_en_i(tick),
      .cmp_upper_i(period_compare_upper_r),
      .count_o(count),
      .match_o(match)
   );

   // Sequencer: idle until run in warm-up mode, done after match until run cleared
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
            if (upper_stage_run && warmup_mode)
               state_nxt = ST_RUN;
         ST_RUN:
            if (!upper_stage_run)
               state_nxt = ST_IDLE;
            else if (match)
               state_nxt = ST_DONE;
         ST_DONE:
            if (!upper_stage_run)
               state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state_r <= ST_IDLE;
      else if (ce_i)
         state_r <= state_nxt;
   end

   // Oscillator and system clock controls
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         system_control_two_r <= SYS_CTRL2_RST;
      else if (ce_i && wr_stb && hit_adr(req, ADR_SYS_CTRL2))
         system_control_two_r <= wr_byte(system_control_two_r, req);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         lower_stage_control_r <= STAGE_CTRL_RST;
         upper_stage_control_r <= STAGE_CTRL_RST;
      end
      else if (ce_i && wr_stb)
      begin
         if (hit_adr(req, ADR_LOWER_CTRL))
            lower_stage_control_r <= wr_byte(lower_stage_control_r, req);
         if (hit_adr(req, ADR_UPPER_CTRL))
            upper_stage_control_r <= wr_byte(upper_stage_control_r, req);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         period_compare_lower_r <= PERIOD_RST[7:0];
         period_compare_upper_r <= PERIOD_RST[15:8];
      end
      else if (ce_i && wr_stb && hit_adr(req, ADR_PERIOD))
      begin
         if (sel_i[0])
            period_compare_lower_r <= dat_i[7:0];
         if (sel_i[1])
            period_compare_upper_r <= dat_i[15:8];
      end
   end

   // Sticky match flag; a new match wins over a write-one clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_stat_r <= 1'b0;
      else if (ce_i)
      begin
         if (match && state_r == ST_RUN)
            irq_stat_r <= 1'b1;
         else if (wr_stb && hit_adr(req, ADR_IRQ_STAT) && sel_i[0] && dat_i[0])
            irq_stat_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_mask_r <= 1'b0;
      else if (ce_i && wr_stb && hit_adr(req, ADR_IRQ_MASK) && sel_i[0])
         irq_mask_r <= dat_i[0];
   end

   always_comb
   begin
      case (adr_i)
         ADR_SYS_CTRL2: rd_data = {24'h000000, system_control_two_r};
         ADR_LOWER_CTRL: rd_data = {24'h000000, lower_stage_control_r};
         ADR_UPPER_CTRL: rd_data = {24'h000000, upper_stage_control_r};
         ADR_PERIOD: rd_data = {16'h0000, period_compare_upper_r, period_compare_lower_r};
         ADR_COUNT: rd_data = {16'h0000, count};
         ADR_IRQ_STAT: rd_data = {31'h00000000, irq_stat_r};
         ADR_IRQ_MASK: rd_data = {31'h00000000, irq_mask_r};
         default: rd_data = UNMAPPED_DATA;
      endcase
   end

   // One-wait-state slave: ack one cycle after strobe, dropped the next
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         ack_o <= cyc_i & stb_i & ~ack_o;
         dat_o <= rd_data;
      end
   end

   // Outputs come from flip-flops
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         osc_o <= '{fast_en: SYS_CTRL2_RST[SYS_FAST_EN_BIT],
                    slow_en: SYS_CTRL2_RST[SYS_SLOW_EN_BIT],
                    slow_sel: SYS_CTRL2_RST[SYS_SLOW_SEL_BIT]};
         irq_o <= 1'b0;
         lower_output_flipflop_o <= 1'b0;
         upper_output_flipflop_o <= 1'b0;
      end
      else if (ce_i)
      begin
         osc_o.fast_en <= system_control_two_r[SYS_FAST_EN_BIT];
         osc_o.slow_en <= system_control_two_r[SYS_SLOW_EN_BIT];
         osc_o.slow_sel <= system_control_two_r[SYS_SLOW_SEL_BIT];
         irq_o <= irq_stat_r & irq_mask_r;
         // Output flip-flops stay at their control value; warm-up never toggles them
         lower_output_flipflop_o <= lower_stage_control_r[OUT_FF_BIT];
         upper_output_flipflop_o <= upper_stage_control_r[OUT_FF_BIT];
      end
   end
endmodule : owc_top

// File: owc_assertions.sv
// Checker for the warm-up counter top: bus handshake, control copies, interrupt.
// Assumes ce_i is high whenever the bus is busy; sees only the top module's ports.
`timescale 1ns/10ps
module owc_chk
import owc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire owc_pkg::owc_osc_s osc_o,
   input wire logic irq_o
);
   logic rd_sys_r;
   logic rd_unm_r;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_wr(logic [7:0] a);
      cyc_i && stb_i && !ack_o && we_i && sel_i[0] && adr_i == a;
   endsequence
   // Remember which read is being answered
   always_ff @(posedge clk_i)
   begin
      rd_sys_r <= cyc_i && stb_i && !ack_o && !we_i && adr_i == ADR_SYS_CTRL2;
      rd_unm_r <= cyc_i && stb_i && !ack_o && !we_i && adr_i > ADR_IRQ_MASK;
   end
   a_ack_next: assert property (s_req |=> ack_o) else $error("no ack after request");
   a_ack_once: assert property (ack_o |=> !ack_o) else $error("ack held too long");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i) && $past(stb_i))
      else $error("ack without request");
   a_osc_copy: assert property (s_wr(ADR_SYS_CTRL2) |-> ##2 osc_o == $past(dat_i[7:5], 2))
      else $error("oscillator controls do not follow write");
   a_read_sys: assert property (ack_o && rd_sys_r |-> dat_o[7:5] == osc_o)
      else $error("control readback differs from outputs");
   a_unmapped_zero: assert property (ack_o && rd_unm_r |-> dat_o == UNMAPPED_DATA)
      else $error("unmapped read not zero");
   a_irq_masked: assert property (s_wr(ADR_IRQ_MASK) ##0 !dat_i[0] |-> ##2 !irq_o)
      else $error("masked interrupt still high");
   a_reset_vals: assert property ($fell(rst_i) |-> osc_o == SYS_CTRL2_RST[7:5] && !ack_o && !irq_o)
      else $error("outputs wrong after reset");
endmodule : owc_chk

bind owc_top owc_chk i_owc_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .osc_o(osc_o), .irq_o(irq_o));

// File: tb_top.sv
// Self-checking bench: Wishbone accesses and warm-up counting from both oscillator sources.
// Assumes the checker is bound to owc_top.
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top
import owc_pkg::*;
;
   logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, irq_o, ff_lo, ff_up;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, q;
   logic [1:0] tk;
   owc_osc_s osc_o;
   int fails = 0;
   int comparisons = 0;
   logic [7:0] pre [2] = '{8'hC0, 8'hE0};
   logic [7:0] lo [2] = '{8'h43, 8'h63};
   logic [7:0] sw [2] = '{8'hE0, 8'hC0};
   logic [7:0] off [2] = '{8'h60, 8'h80};

   owc_top i_owc_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .slow_tick_i(tk[0]), .fast_tick_i(tk[1]), .osc_o(osc_o), .lower_output_flipflop_o(ff_lo),
      .upper_output_flipflop_o(ff_up), .irq_o(irq_o));

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 50);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 50)
         fails++;
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask : rd

   // Drives the oscillator levels picked by m; only the selected source may count
   task automatic tick(input int n, input logic [1:0] m);
      repeat (n)
      begin
         @(posedge clk_i);
         tk <= m;
         @(posedge clk_i);
         tk <= 2'h0;
      end
      repeat (4) @(posedge clk_i);
   endtask : tick

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report

   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   initial
   begin
      repeat (20000) @(posedge clk_i);
      fails++;
      final_report();
   end

   initial
   begin
      {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, tk} = {1'b1, 45'h0};
      sel_i = 4'hF;
      ce_i = 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ADR_SYS_CTRL2, 32'h80);
      rd(ADR_LOWER_CTRL, 32'h0);
      rd(ADR_UPPER_CTRL, 32'h0);
      rd(ADR_PERIOD, 32'hFFFF);
      rd(ADR_IRQ_STAT, 32'h0);
      rd(ADR_IRQ_MASK, 32'h0);
      wb(1'b1, 8'h40, 32'hFFFF_FFFF);
      rd(8'h40, UNMAPPED_DATA);
      wb(1'b1, ADR_COUNT, 32'h1234);
      rd(ADR_COUNT, 32'h0);
      wb(1'b1, ADR_LOWER_CTRL, 32'h80);
      wb(1'b1, ADR_UPPER_CTRL, 32'h80);
      @(posedge clk_i);
      `CHK({ff_lo, ff_up}, 2'h3)
      wb(1'b1, ADR_LOWER_CTRL, 32'h0);
      wb(1'b1, ADR_UPPER_CTRL, 32'h0);
      @(posedge clk_i);
      `CHK({ff_lo, ff_up}, 2'h0)
      for (int i = 0; i < 2; i++)
      begin
         wb(1'b1, ADR_SYS_CTRL2, {24'h0, pre[i]});
         wb(1'b1, ADR_LOWER_CTRL, {24'h0, lo[i]});
         wb(1'b1, ADR_UPPER_CTRL, 32'h08);
         tick(4, 2'h3);
         rd(ADR_COUNT, 32'h0);
         wb(1'b1, ADR_UPPER_CTRL, 32'h05);
         wb(1'b1, ADR_PERIOD, i ? 32'h0100 : 32'h01FF);
         wb(1'b1, ADR_IRQ_MASK, {31'h0, i == 0});
         wb(1'b1, ADR_UPPER_CTRL, 32'h0D);
         tick(4, i ? 2'h1 : 2'h2);
         rd(ADR_COUNT, 32'h0);
         ce_i <= 1'b0;
         tick(4, 2'h3);
         ce_i <= 1'b1;
         rd(ADR_COUNT, 32'h0);
         tick(256, 2'h3);
         rd(ADR_COUNT, 32'h0100);
         `CHK(irq_o, 1'b0)
         tick(1, 2'h3);
         `CHK(irq_o, i == 0)
         rd(ADR_COUNT, 32'h0);
         rd(ADR_IRQ_STAT, 32'h1);
         if (i == 1)
         begin
            wb(1'b1, ADR_IRQ_MASK, 32'h1);
            repeat (2) @(posedge clk_i);
            `CHK(irq_o, 1'b1)
         end
         wb(1'b1, ADR_UPPER_CTRL, 32'h05);
         wb(1'b1, ADR_IRQ_STAT, 32'h1);
         rd(ADR_IRQ_STAT, 32'h0);
         `CHK(irq_o, 1'b0)
         wb(1'b1, ADR_SYS_CTRL2, {24'h0, sw[i]});
         @(posedge clk_i);
         `CHK(osc_o, sw[i][7:5])
         wb(1'b1, ADR_SYS_CTRL2, {24'h0, off[i]});
         @(posedge clk_i);
         `CHK(osc_o, off[i][7:5])
      end
      final_report();
   end
endmodule : tb_top
